// ---- core/dsc_sector_check.sv ----
/*
 * Read-side sector check, end-of-sector sequencing, shutdown gating and
 * drive selection for a serial disc data path.
 * Assumes asynchronous drive/control-board pins, pulses several clocks wide.
 */
//
// Contract
// RL1: Check register uses polynomial x^12+x^11+x^3+x^2+x+1 on serial bits.
// RL2: Register clears at sector clock lead, steps at bit clock trail.
// RL3: Sector is forty 12-bit data words then one check word.
// RL4: All 41 words through the register leave zero; non-zero means suspect.
// RL5: Read bits feed the register only while read command is active.
// RL6: After word forty the feedback stays on so check word folds in.
// RL7: Write data output held high during a read.
// RL8: After last check bit, any non-zero register bit sets error flag.
// RL9: Error shows active low on status bit three during status read.
// RL10: Write sync clears the error flag.
// RL11: Error flag sampled only in read, after word forty, command active.
// RL12: Word 41 completion sets end flop, ends read, samples error, blocks input.
// RL13: With read command gone the register input is low, remainder held.
// RL14: End flop removes write command at check word completion.
// RL15: Control board holds match-at-sector-clock low in shutdown; counter reset.
// RL16: In shutdown both matches drop; commands off, write data high.
// RL17: Shutdown suppresses read-word-ready and preamble-load strobes.
// RL18: Word complete pulse suppressed while bit counter held reset.
// RL19: Two select bits choose one of four drives, low bit first.
// RL20: Each drive enables its bus drivers only on a select match.
// RL21: Error flag stays set until the clearing condition.
`timescale 1ns/100ps
`default_nettype none

module dsc_sector_check (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic sector_clock_i,
	input wire logic bit_clock_pulse_i,
	input wire logic read_data_i,
	input wire logic read_match_n_i,
	input wire logic write_match_n_i,
	input wire logic match_at_sector_clock_n_i,
	input wire logic write_sync_n_i,
	input wire logic read_status_iot_i,
	input wire logic write_bit_i,
	input wire logic [1:0] reg_addr_i,
	input wire logic [11:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [11:0] reg_rdata_o,
	output logic read_command_o,
	output logic write_command_o,
	output logic write_data_o,
	output logic status_bit_three_n_o,
	output logic read_word_ready_o,
	output logic preamble_load_o,
	output logic word_complete_pulse_o,
	output logic [3:0] drive_select_o
);
	import dsc_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [NPIN-1:0] pins, s1_reg, s2_reg, s3_reg, pin_reg, prev_reg;

	assign pins = {read_status_iot_i, write_sync_n_i, match_at_sector_clock_n_i,
		write_match_n_i, read_match_n_i, read_data_i, bit_clock_pulse_i, sector_clock_i};

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s1_reg <= PIN_RST;
			s2_reg <= PIN_RST;
			s3_reg <= PIN_RST;
			pin_reg <= PIN_RST;
			prev_reg <= PIN_RST;
		end else if (ce_i) begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < NPIN; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					pin_reg[i] <= s3_reg[i];
				end
			end
			prev_reg <= pin_reg;
		end
	end

	logic sc_lead, sc_trail, bit_trail, rd_bit;
	logic read_match, write_match, shutdown, wsync, iot;

	assign sc_lead = pin_reg[P_SECT] & ~prev_reg[P_SECT];
	assign sc_trail = ~pin_reg[P_SECT] & prev_reg[P_SECT];
	assign bit_trail = ~pin_reg[P_BIT] & prev_reg[P_BIT];
	assign rd_bit = pin_reg[P_RDAT];
	assign read_match = ~pin_reg[P_RMATCH_N];
	assign write_match = ~pin_reg[P_WMATCH_N];
	assign shutdown = ~pin_reg[P_MSC_N];
	assign wsync = ~pin_reg[P_WSYNC_N];
	assign iot = pin_reg[P_IOT];

	// ----------------------------------------
	// Bit and word counters
	// ----------------------------------------
	logic [3:0] cnt_reg;
	logic [5:0] wrd_reg;
	logic word40, wcp;

	assign word40 = (wrd_reg == DATA_WORDS);
	assign wcp = bit_trail && (cnt_reg == BIT_LAST) && !shutdown; // RL18

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cnt_reg <= 4'h0;
		end else if (ce_i) begin
			if (shutdown || sc_lead) begin
				cnt_reg <= 4'h0; // RL15
			end else if (bit_trail) begin
				cnt_reg <= (cnt_reg == BIT_LAST) ? 4'h0 : cnt_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			wrd_reg <= 6'h00;
		end else if (ce_i) begin
			if (sc_lead) begin
				wrd_reg <= 6'h00;
			end else if (wcp && !word40) begin
				wrd_reg <= wrd_reg + 6'h01; // RL3
			end
		end
	end

	// ----------------------------------------
	// End-of-sector flop and commands
	// ----------------------------------------
	logic eos_reg, eos_set, read_cmd_reg, write_cmd_reg;

	assign eos_set = wcp && word40; // RL12

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			eos_reg <= 1'b0;
		end else if (ce_i) begin
			if (sc_lead) begin
				eos_reg <= 1'b0;
			end else if (eos_set) begin
				eos_reg <= 1'b1; // RL12
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			read_cmd_reg <= 1'b0;
		end else if (ce_i) begin
			if (eos_set || !read_match) begin
				read_cmd_reg <= 1'b0; // RL12 RL16
			end else if (sc_trail) begin
				read_cmd_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			write_cmd_reg <= 1'b0;
		end else if (ce_i) begin
			if (eos_set || !write_match) begin
				write_cmd_reg <= 1'b0; // RL14 RL16
			end else if (sc_trail) begin
				write_cmd_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Check register
	// ----------------------------------------
	logic [11:0] crc_reg;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			crc_reg <= CRC_RST;
		end else if (ce_i) begin
			if (sc_lead) begin
				crc_reg <= CRC_RST; // RL2
			end else if (bit_trail && read_cmd_reg) begin
				crc_reg <= crc_step(crc_reg, rd_bit); // RL1 RL5 RL6 RL13
			end
		end
	end

	// ----------------------------------------
	// Error flag and status
	// ----------------------------------------
	logic samp_reg, err_reg;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			samp_reg <= 1'b0;
		end else if (ce_i) begin
			samp_reg <= eos_set && read_match && read_cmd_reg; // RL11
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			err_reg <= 1'b0;
		end else if (ce_i) begin
			if (wsync) begin
				err_reg <= 1'b0; // RL10
			end else if (samp_reg && (crc_reg != CRC_RST)) begin
				err_reg <= 1'b1; // RL4 RL8 RL21
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			status_bit_three_n_o <= 1'b1;
		end else if (ce_i) begin
			status_bit_three_n_o <= ~(err_reg && iot); // RL9
		end
	end

	// ----------------------------------------
	// Drive-side outputs and strobes
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			read_command_o <= 1'b0;
			write_command_o <= 1'b0;
			write_data_o <= 1'b1;
		end else if (ce_i) begin
			read_command_o <= read_cmd_reg && !eos_set && read_match;
			write_command_o <= write_cmd_reg && !eos_set && write_match;
			if (read_cmd_reg || !write_match || !write_cmd_reg) begin
				write_data_o <= 1'b1; // RL7 RL16
			end else begin
				write_data_o <= write_bit_i;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			word_complete_pulse_o <= 1'b0;
			read_word_ready_o <= 1'b0;
			preamble_load_o <= 1'b0;
		end else if (ce_i) begin
			word_complete_pulse_o <= wcp; // RL18
			read_word_ready_o <= wcp && read_cmd_reg && !word40; // RL17
			preamble_load_o <= wcp && write_match && !word40; // RL17
		end
	end

	// ----------------------------------------
	// Register port and drive select
	// ----------------------------------------
	logic [1:0] ctrl_reg;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ctrl_reg <= CTRL_RST;
		end else if (ce_i && reg_wr_i && reg_addr_i == ADDR_CTRL) begin
			ctrl_reg <= reg_wdata_i[1:0];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			drive_select_o <= 4'h1;
		end else if (ce_i) begin
			drive_select_o <= 4'h1 << {ctrl_reg[CT_SEL_HI], ctrl_reg[CT_SEL_LO]}; // RL19
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			reg_rdata_o <= 12'h000;
		end else if (ce_i) begin
			reg_rdata_o <= 12'h000;
			if (reg_rd_i) begin
				unique case (reg_addr_i)
					ADDR_STAT: begin
						reg_rdata_o[ST_ERR] <= err_reg;
						reg_rdata_o[ST_EOS] <= eos_reg;
						reg_rdata_o[ST_RCMD] <= read_cmd_reg;
						reg_rdata_o[ST_WCMD] <= write_cmd_reg;
						reg_rdata_o[ST_W40] <= word40;
					end
					ADDR_REM: reg_rdata_o <= crc_reg;
					ADDR_CTRL: reg_rdata_o[1:0] <= ctrl_reg;
					default: reg_rdata_o <= 12'h000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_crc_clear_sc: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL2
		ce_i && sc_lead |=> crc_reg == CRC_RST)
		else $error("check register not cleared at sector clock");
	a_crc_step_bit: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL1
		ce_i && bit_trail && read_cmd_reg && !sc_lead
		|=> crc_reg == crc_step($past(crc_reg), $past(rd_bit)))
		else $error("check register step wrong");
	a_crc_hold_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL13
		ce_i && !read_cmd_reg && !sc_lead |=> $stable(crc_reg))
		else $error("remainder changed without read command");
	a_wdata_read_high: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL7
		ce_i && read_cmd_reg |=> write_data_o)
		else $error("write data low during read");
	a_err_sample_set: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL8
		ce_i && samp_reg && crc_reg != CRC_RST && !wsync |=> err_reg)
		else $error("non-zero remainder did not set error");
	a_err_window_only: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL11
		ce_i && !samp_reg && !err_reg |=> !err_reg)
		else $error("error flag set outside sampling window");
	a_status_bit_low: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL9
		ce_i && err_reg && iot |=> !status_bit_three_n_o)
		else $error("status bit three not asserted");
	a_status_bit_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL9
		ce_i && !iot |=> status_bit_three_n_o)
		else $error("status bit three driven without status read");
	a_err_sync_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL10
		ce_i && wsync |=> !err_reg)
		else $error("write sync did not clear error");
	a_err_flag_sticky: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL21
		ce_i && err_reg && !wsync |=> err_reg)
		else $error("error flag dropped without write sync");
	a_eos_stops_cmds: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL12
		ce_i && eos_set |=> eos_reg && !read_cmd_reg && !write_cmd_reg
		&& !read_command_o && !write_command_o)
		else $error("end of sector did not stop commands");
	a_shut_cmds_off: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL16
		ce_i && !read_match && !write_match |=> !read_cmd_reg && !write_cmd_reg ##1
		!read_command_o && !write_command_o && write_data_o)
		else $error("commands active in shutdown");
	a_shut_strobes_off: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL17
		ce_i && shutdown |=> !read_word_ready_o && !preamble_load_o
		&& !word_complete_pulse_o)
		else $error("strobe issued in shutdown");
	a_word_count_max: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL3
		wrd_reg <= DATA_WORDS && cnt_reg <= BIT_LAST)
		else $error("word or bit counter out of range");
	a_drive_sel_onehot: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL19
		ce_i && !(reg_wr_i && reg_addr_i == ADDR_CTRL) ##1 ce_i
		|=> drive_select_o == 4'h1 << {$past(ctrl_reg[CT_SEL_HI], 2), $past(ctrl_reg[CT_SEL_LO], 2)})
		else $error("drive select decode wrong");

endmodule : dsc_sector_check

`default_nettype wire

// ---- core/dsc_pkg.sv ----
/*
 * Constants and the check-register step function for the sector check block.
 * Assumes a single 10 MHz system clock; no other dependencies.
 */
package dsc_pkg;

	// ----------------------------------------
	// Pin vector positions
	// ----------------------------------------
	localparam int NPIN = 8;
	localparam int P_SECT = 0;
	localparam int P_BIT = 1;
	localparam int P_RDAT = 2;
	localparam int P_RMATCH_N = 3;
	localparam int P_WMATCH_N = 4;
	localparam int P_MSC_N = 5;
	localparam int P_WSYNC_N = 6;
	localparam int P_IOT = 7;
	localparam logic [7:0] PIN_RST = 8'h78;

	// ----------------------------------------
	// Sector format and check polynomial
	// ----------------------------------------
	localparam int WORD_BITS = 12;
	localparam logic [3:0] BIT_LAST = 4'hb;
	localparam logic [5:0] DATA_WORDS = 6'h28;
	// x^12+x^11+x^3+x^2+x+1, bit-reversed for right shift
	localparam logic [11:0] CRC_POLY_R = 12'hf01;
	localparam logic [11:0] CRC_RST = 12'h000;

	// ----------------------------------------
	// Register port map
	// ----------------------------------------
	localparam logic [1:0] ADDR_STAT = 2'h0;
	localparam logic [1:0] ADDR_REM = 2'h1;
	localparam logic [1:0] ADDR_CTRL = 2'h2;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam int ST_ERR = 0;
	localparam int ST_EOS = 1;
	localparam int ST_RCMD = 2;
	localparam int ST_WCMD = 3;
	localparam int ST_W40 = 4;
	localparam int CT_SEL_LO = 0;
	localparam int CT_SEL_HI = 1;

	function automatic logic [11:0] crc_step(input logic [11:0] crc, input logic din);
		logic fb;
		fb = crc[0] ^ din;
		crc_step = (crc >> 1) ^ (fb ? CRC_POLY_R : CRC_RST);
	endfunction : crc_step

endpackage : dsc_pkg

// ---- tb/dsc_disc_model.sv ----
/*
 * Disc drive model: sector pulse, bit clock and serial read data.
 * Assumes sector() is called just after a rising edge of the system clock.
 */
`timescale 1ns/100ps
`default_nettype none

module dsc_disc_model #(
	parameter int UNIT = 0
) (
	input wire logic clk_sys_i,
	input wire logic read_command_i,
	input wire logic [3:0] drive_select_i,
	output logic sector_clock_o,
	output logic bit_clock_o,
	output logic read_data_o
);
	logic bit_val = 1'b0;
	logic junk = 1'b0;

	initial begin
		sector_clock_o = 1'b0;
		bit_clock_o = 1'b0;
	end

	// ----------------------------------------
	// Line carries read data only when selected and commanded, toggling junk otherwise
	// ----------------------------------------
	always @(posedge clk_sys_i) junk <= ~junk;
	assign read_data_o = (drive_select_i[UNIT] && read_command_i) ? bit_val : junk;

	// ----------------------------------------
	// One sector: 41 words, postamble bits after
	// ----------------------------------------
	task automatic sector(input logic [11:0] w [41], input int extra);
		sector_clock_o <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		sector_clock_o <= 1'b0;
		repeat (20) @(posedge clk_sys_i);
		for (int i = 0; i < 492 + extra; i++) begin
			bit_val <= (i < 492) ? w[i / 12][i % 12] : i[0];
			bit_clock_o <= 1'b1;
			repeat (6) @(posedge clk_sys_i);
			bit_clock_o <= 1'b0;
			repeat (6) @(posedge clk_sys_i);
		end
	endtask : sector

endmodule : dsc_disc_model
`default_nettype wire

// ---- tb/tb.sv ----
/*
 * Self-checking bench for the sector check block.
 * Assumes the disc drive model and the design package are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("FAIL %s expected %h seen %h", nm, ex, got); end end

module tb;
	import dsc_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic sc, bc, rd;
	logic read_match_n_i = 1'b1, write_match_n_i = 1'b1, msc_n = 1'b1;
	logic wsync_n = 1'b1, iot = 1'b0, write_bit_i = 1'b0;
	logic [1:0] reg_addr_i = 2'h0;
	logic [11:0] reg_wdata_i = 12'h000, reg_rdata_o;
	logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_pend = 1'b0, ce = 1'b1;
	logic rcmd, wcmd, wdat, st_n, rwr, pre, wcp;
	logic [3:0] dsel;
	logic [11:0] words [41];
	logic [11:0] exp_q [$];
	int checked = 0, n_mismatch = 0, cycles = 0, n_rwr = 0, n_pre = 0, n_wcp = 0;

	always #50 clk_sys_i = ~clk_sys_i;

	dsc_sector_check uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
		.sector_clock_i(sc), .bit_clock_pulse_i(bc), .read_data_i(rd),
		.read_match_n_i(read_match_n_i), .write_match_n_i(write_match_n_i),
		.match_at_sector_clock_n_i(msc_n), .write_sync_n_i(wsync_n),
		.read_status_iot_i(iot), .write_bit_i(write_bit_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .read_command_o(rcmd), .write_command_o(wcmd),
		.write_data_o(wdat), .status_bit_three_n_o(st_n), .read_word_ready_o(rwr),
		.preamble_load_o(pre), .word_complete_pulse_o(wcp), .drive_select_o(dsel));

	dsc_disc_model #(.UNIT(0)) dsk (.clk_sys_i(clk_sys_i), .read_command_i(rcmd),
		.drive_select_i(dsel), .sector_clock_o(sc), .bit_clock_o(bc), .read_data_o(rd));

	// ----------------------------------------
	// Watchers, counters, timeout
	// ----------------------------------------
	always @(posedge clk_sys_i) begin
		rd_pend <= reg_rd_i;
		write_bit_i <= 1'($urandom);
		n_rwr <= n_rwr + int'(rwr === 1'b1);
		n_pre <= n_pre + int'(pre === 1'b1);
		n_wcp <= n_wcp + int'(wcp === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_mismatch++;
			stop_test();
		end
	end
	always @(negedge clk_sys_i) begin
		if (rd_pend === 1'b1) `CHK("reg_rdata_o", exp_q.pop_front(), reg_rdata_o)
		if (rcmd === 1'b1) `CHK("write_data_o", 1'b1, wdat)
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic reg_wr(input logic [1:0] a, input logic [11:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [1:0] a, input logic [11:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
	endtask : reg_rd

	function automatic logic [11:0] crc(input logic [11:0] w [41], input int n);
		logic [11:0] c;
		c = 12'h000;
		for (int i = 0; i < n * 12; i++)
			c = (c >> 1) ^ ((c[0] ^ w[i / 12][i % 12]) ? CRC_POLY_R : 12'h000);
		return c;
	endfunction : crc

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask : settle

	task automatic stop_test();
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [11:0] bad;
		void'($urandom(32'h278b1890));
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		settle(1);
		`CHK("drive_select_o", 4'b0001, dsel)
		for (int i = 3; i >= 0; i--) begin
			reg_wr(ADDR_CTRL, 12'(i));
			settle(2);
			`CHK("drive_select_o", 4'b0001 << i, dsel)
			reg_rd(ADDR_CTRL, 12'(i));
		end
		reg_rd(2'h3, 12'h000);
		ce <= 1'b0;
		reg_wr(ADDR_CTRL, 12'h003);
		settle(2);
		`CHK("drive_select_o", 4'b0001, dsel)
		@(posedge clk_sys_i);
		ce <= 1'b1;
		for (int i = 0; i < 40; i++) words[i] = 12'($urandom);
		words[40] = crc(words, 40);
		read_match_n_i <= 1'b0;
		dsk.sector(words, 0);
		settle(10);
		`CHK("read_command_o", 1'b0, rcmd)
		`CHK("read_word_ready count", 40, n_rwr)
		`CHK("word_complete count", 41, n_wcp)
		reg_rd(ADDR_REM, 12'h000);
		reg_rd(ADDR_STAT, 12'((1 << ST_EOS) | (1 << ST_W40)));
		iot <= 1'b1;
		settle(8);
		`CHK("status_bit_three_n_o", 1'b1, st_n)
		@(posedge clk_sys_i);
		iot <= 1'b0;
		words[40] = words[40] ^ (12'h001 << ($urandom % 12));
		bad = crc(words, 41);
		dsk.sector(words, 24);
		settle(10);
		`CHK("status_bit_three_n_o", 1'b1, st_n)
		reg_wr(ADDR_REM, ~bad);
		reg_rd(ADDR_REM, bad);
		reg_rd(ADDR_STAT, 12'((1 << ST_ERR) | (1 << ST_EOS) | (1 << ST_W40)));
		iot <= 1'b1;
		settle(8);
		`CHK("status_bit_three_n_o", 1'b0, st_n)
		words[40] = crc(words, 40);
		@(posedge clk_sys_i);
		dsk.sector(words, 0);
		settle(10);
		`CHK("status_bit_three_n_o", 1'b0, st_n)
		@(posedge clk_sys_i);
		wsync_n <= 1'b0;
		settle(8);
		@(posedge clk_sys_i);
		wsync_n <= 1'b1;
		settle(8);
		`CHK("status_bit_three_n_o", 1'b1, st_n)
		@(posedge clk_sys_i);
		read_match_n_i <= 1'b1;
		write_match_n_i <= 1'b0;
		fork
			dsk.sector(words, 0);
			begin
				settle(400);
				`CHK("write_command_o", 1'b1, wcmd)
			end
		join
		settle(10);
		`CHK("write_command_o", 1'b0, wcmd)
		`CHK("preamble_load count", 40, n_pre)
		@(posedge clk_sys_i);
		write_match_n_i <= 1'b1;
		msc_n <= 1'b0;
		settle(8);
		n_rwr <= 0;
		n_pre <= 0;
		n_wcp <= 0;
		@(posedge clk_sys_i);
		dsk.sector(words, 0);
		settle(10);
		`CHK("word_complete count", 0, n_wcp)
		`CHK("read_word_ready count", 0, n_rwr)
		`CHK("preamble_load count", 0, n_pre)
		`CHK("read_command_o", 1'b0, rcmd)
		`CHK("write_data_o", 1'b1, wdat)
		stop_test();
	end

endmodule : tb
`default_nettype wire
